// File: flash_host_ctrl.sv
// apb-driven host that issues auxiliary-mode command sequences to a flash
// assumes the flash pins are asynchronous to pclk and dq is resolved outside
// Function
// - after a buffer abort the host clears it with AA@555, 55@2AA, F0@555.
// - in lock mode A0 arms a program on the next write; F0, or 90 then 00 or F0, exits.
// - secure mode reads its data; 70@555 stays, F0 leaves, AA@555 unlocks.
// - next 55@2AA; then A0@555, 25@sector, 90@555.
// - once the count has run out only 29 at the loaded sector confirms.
`timescale 1ns/1ps
module flash_host_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
  output flash_host_pkg::flash_bus_t flash_out
);
  import flash_host_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // command sequences

  function automatic logic is_unlock_op(input op_t op);
    return op == op_fault_clear || op == op_secure_word ||
           op == op_buffer_open || op == op_secure_exit;
  endfunction : is_unlock_op

  function automatic cycle_t step_of(input op_t op, input logic [2:0] idx,
                                     input logic [ADDR_W-1:0] a,
                                     input logic [DATA_W-1:0] d,
                                     input logic [DATA_W-1:0] cnt,
                                     input logic [ADDR_W-1:0] sa);
    cycle_t c;
    c = '{is_read: 1'b0, last: 1'b1, addr: a, data: d};
    if (is_unlock_op(op) && idx < 3'd2) begin
      // unlock prefix, low address bits only
      c.last = 1'b0;
      c.addr = idx[0] ? CMD_ADDR_B : CMD_ADDR_A;
      c.data = idx[0] ? CMD_UNLOCK_B : CMD_UNLOCK_A;
    end else begin
      case (op)
        op_read: c.is_read = 1'b1;
        op_status: begin
          // status entry then read, also valid while a program runs
          c.is_read = idx != 3'd0;
          c.last = idx != 3'd0;
          if (idx == 3'd0) begin
            c.addr = CMD_ADDR_A;
            c.data = CMD_STATUS;
          end
        end
        op_reset: c.data = CMD_RESET;
        op_query_exit: c.data = CMD_QUERY_EXIT;
        op_fault_clear: begin
          c.addr = CMD_ADDR_A;
          c.data = CMD_RESET;
        end
        op_lock_program: begin
          c.last = idx != 3'd0;
          if (idx == 3'd0) c.data = CMD_ARM;
        end
        op_lock_exit: begin
          c.last = idx != 3'd0;
          c.data = (idx == 3'd0) ? CMD_EXIT_ENTRY : CMD_EXIT;
        end
        op_secure_word: begin
          c.last = idx == 3'd3;
          if (idx == 3'd2) begin
            c.addr = CMD_ADDR_A;
            c.data = CMD_ARM;
          end
        end
        op_buffer_open: begin
          c.last = idx == 3'd3;
          c.data = (idx == 3'd2) ? CMD_BUF_LOAD : cnt;
        end
        op_secure_exit: begin
          c.last = idx == 3'd3;
          c.addr = (idx == 3'd2) ? CMD_ADDR_A : a;
          c.data = (idx == 3'd2) ? CMD_EXIT_ENTRY : CMD_EXIT;
        end
        op_buffer_confirm: begin
          c.addr = sa;
          c.data = CMD_CONFIRM;
        end
        default: c.last = 1'b1;
      endcase
    end
    return c;
  endfunction : step_of

  ////////////////////////////////////////////////////////////////////////////
  // registers and apb decode

  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] data_reg;
  logic [7:0] count_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_mask;
  logic [7:0] words_left;
  logic [ADDR_W-1:SECTOR_LSB] sector_q;
  op_t op_q;
  logic [2:0] step_q;
  state_t state_q;
  logic [3:0] cnt_q;
  cycle_t cur_q;
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;

  wire apb_wr = psel && penable && pwrite;
  wire sel_ctrl = paddr == OFS_CTRL;
  wire sel_addr = paddr == OFS_ADDR;
  wire sel_data = paddr == OFS_DATA;
  wire sel_count = paddr == OFS_COUNT;
  wire sel_rdata = paddr == OFS_RDATA;
  wire sel_stat = paddr == OFS_STAT;
  wire sel_irq_status = paddr == OFS_IRQ_STATUS;
  wire sel_irq_mask = paddr == OFS_IRQ_MASK;
  wire hit = sel_ctrl | sel_addr | sel_data | sel_count | sel_rdata |
             sel_stat | sel_irq_status | sel_irq_mask;
  wire busy = state_q != st_idle;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = sel_ctrl ? {28'h0000000, op_q} :
                  sel_addr ? {10'h000, addr_reg} :
                  sel_data ? {16'h0000, data_reg} :
                  sel_count ? {24'h000000, count_reg} :
                  sel_rdata ? {16'h0000, rdata_reg} :
                  sel_stat ? {23'h000000, busy, words_left} :
                  sel_irq_status ? {30'h00000000, irq_status} :
                  sel_irq_mask ? {30'h00000000, irq_mask} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // request check; refusals keep the flash from seeing an invalid pair

  wire ctrl_wr = apb_wr && sel_ctrl;
  wire op_t req_op = op_t'(pwdata[3:0]);
  wire in_sector = addr_reg[ADDR_W-1:SECTOR_LSB] == sector_q;
  wire [ADDR_W-1:0] sector_addr = {sector_q, {SECTOR_LSB{1'b0}}};
  wire cond_ok =
    (req_op == op_buffer_open) ? count_reg <= MAX_WORD_COUNT :
    (req_op == op_buffer_word) ?
      words_left != 8'h00 && in_sector :
    (req_op == op_buffer_confirm) ? words_left == 8'h00 : 1'b1;
  wire start = ctrl_wr && !busy && pwdata[3:0] <= OP_LAST_CODE && cond_ok;
  wire refuse = ctrl_wr && !start;
  wire [DATA_W-1:0] cnt_word = {8'h00, count_reg};
  wire cycle_t first_cycle =
    step_of(req_op, 3'd0, addr_reg, data_reg, cnt_word, sector_addr);
  wire cycle_t next_cycle =
    step_of(op_q, step_q + 3'd1, addr_reg, data_reg, cnt_word, sector_addr);
  wire [3:0] pulse_len = cur_q.is_read ? READ_PULSE_CYC : WRITE_PULSE_CYC;
  wire pulse_end = state_q == st_pulse && cnt_q == pulse_len - 4'd1;
  wire recover_end = state_q == st_recover && cnt_q == RECOVER_CYC - 4'd1;
  wire done = recover_end && cur_q.last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= '0;
      data_reg <= '0;
      count_reg <= 8'h00;
      irq_mask <= IRQ_MASK_RESET;
      irq_status <= '0;
    end else begin
      if (apb_wr && sel_addr) addr_reg <= pwdata[ADDR_W-1:0];
      if (apb_wr && sel_data) data_reg <= pwdata[DATA_W-1:0];
      if (apb_wr && sel_count) count_reg <= pwdata[7:0];
      if (apb_wr && sel_irq_mask) irq_mask <= pwdata[EV_W-1:0];
      // set wins over a write-one clear in the same cycle
      irq_status <= (irq_status &
                     ~((apb_wr && sel_irq_status) ? pwdata[EV_W-1:0] : '0)) |
                    {refuse, done};
    end
  end

  assign irq = |(irq_status & irq_mask);

  // host mirror of the flash word counter and entry sector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      words_left <= 8'h00;
      sector_q <= '0;
    end else if (start && req_op == op_buffer_open) begin
      words_left <= count_reg + 8'h01;
      sector_q <= addr_reg[ADDR_W-1:SECTOR_LSB];
    end else if (start && req_op == op_buffer_word) begin
      words_left <= words_left - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle engine: setup, strobe pulse, recovery per flash cycle

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_idle;
      op_q <= op_read;
      step_q <= 3'd0;
      cnt_q <= 4'd0;
      cur_q <= '0;
      rdata_reg <= '0;
    end else begin
      unique case (state_q)
        st_idle: if (start) begin
          op_q <= req_op;
          step_q <= 3'd0;
          cur_q <= first_cycle;
          state_q <= st_setup;
        end
        st_setup: begin
          cnt_q <= 4'd0;
          state_q <= st_pulse;
        end
        st_pulse: begin
          cnt_q <= pulse_end ? 4'd0 : cnt_q + 4'd1;
          if (pulse_end) state_q <= st_recover;
          // read data from the flash's own state, status or array
          if (pulse_end && cur_q.is_read) rdata_reg <= dq_s2;
        end
        st_recover: begin
          cnt_q <= cnt_q + 4'd1;
          if (done) state_q <= st_idle;
          else if (recover_end) begin
            step_q <= step_q + 3'd1;
            cur_q <= next_cycle;
            state_q <= st_setup;
          end
        end
      endcase
    end
  end

  // address and data come from flops; strobes decode the state register
  assign flash_out = '{
    ce_n: state_q == st_idle,
    oe_n: !(state_q == st_pulse && cur_q.is_read),
    we_n: !(state_q == st_pulse && !cur_q.is_read),
    dq_oe_n: state_q == st_idle || cur_q.is_read,
    addr: cur_q.addr,
    dq: cur_q.data
  };

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_FAULT_CLEAR: assert property (@(posedge pclk)
    disable iff (!presetn)
    (state_q == st_pulse && op_q == op_fault_clear && step_q == 3'd2) |->
    (!flash_out.we_n && flash_out.dq == CMD_RESET &&
     flash_out.addr == CMD_ADDR_A))
    else $error("fault clear third cycle wrong");

  AST_LOCK_ARM: assert property (@(posedge pclk) disable iff (!presetn)
    (start && req_op == op_lock_program) |=>
    (flash_out.dq == CMD_ARM) ##1 $fell(flash_out.we_n))
    else $error("lock program not armed with A0");

  AST_UNLOCK_ONE: assert property (@(posedge pclk)
    disable iff (!presetn)
    ($fell(flash_out.we_n) && is_unlock_op(op_q) && step_q == 3'd0) |->
    (flash_out.dq == CMD_UNLOCK_A && flash_out.addr == CMD_ADDR_A))
    else $error("first unlock not AA at 555");

  AST_UNLOCK_TWO: assert property (@(posedge pclk)
    disable iff (!presetn)
    ($fell(flash_out.we_n) && is_unlock_op(op_q) && step_q == 3'd1) |->
    (flash_out.dq == CMD_UNLOCK_B && flash_out.addr == CMD_ADDR_B))
    else $error("second unlock not 55 at 2AA");

  AST_CONFIRM: assert property (@(posedge pclk) disable iff (!presetn)
    (start && req_op == op_buffer_confirm) |->
    words_left == 8'h00 ##1
    (flash_out.dq == CMD_CONFIRM && flash_out.addr == sector_addr))
    else $error("confirm issued early or off sector");

  AST_WE_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(flash_out.we_n) |-> !flash_out.we_n[*7] ##1 flash_out.we_n)
    else $error("write pulse width wrong");

  AST_DQ_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    !flash_out.we_n |-> !flash_out.dq_oe_n && flash_out.oe_n)
    else $error("dq not driven during write");

endmodule : flash_host_ctrl

// File: flash_host_pkg.sv
// constants, types and register map of the flash auxiliary-mode host
// assumes a 125 MHz pclk and a 16-bit parallel nor flash on plain pins
package flash_host_pkg;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int SECTOR_LSB = 15;

  // command cycle addresses, high bits left at zero
  localparam logic [ADDR_W-1:0] CMD_ADDR_A = 22'h000555;
  localparam logic [ADDR_W-1:0] CMD_ADDR_B = 22'h0002AA;

  localparam logic [DATA_W-1:0] CMD_UNLOCK_A = 16'h00AA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK_B = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
  localparam logic [DATA_W-1:0] CMD_QUERY_EXIT = 16'h00FF;
  localparam logic [DATA_W-1:0] CMD_ARM = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_EXIT_ENTRY = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_EXIT = 16'h0000;
  localparam logic [DATA_W-1:0] CMD_STATUS = 16'h0070;
  localparam logic [DATA_W-1:0] CMD_BUF_LOAD = 16'h0025;
  localparam logic [DATA_W-1:0] CMD_CONFIRM = 16'h0029;
  localparam logic [7:0] MAX_WORD_COUNT = 8'h7F;

  // timing, figures in ns and derived counts in pclk cycles
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRITE_PULSE_NS = 56;
  localparam int READ_PULSE_NS = 80;
  localparam int RECOVER_NS = 16;
  localparam logic [3:0] WRITE_PULSE_CYC =
    4'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] READ_PULSE_CYC =
    4'((READ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RECOVER_CYC =
    4'((RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // apb register offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ADDR = 12'h004;
  localparam logic [11:0] OFS_DATA = 12'h008;
  localparam logic [11:0] OFS_COUNT = 12'h00C;
  localparam logic [11:0] OFS_RDATA = 12'h010;
  localparam logic [11:0] OFS_STAT = 12'h014;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h018;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h01C;

  localparam int EV_DONE = 0;
  localparam int EV_REFUSED = 1;
  localparam int EV_W = 2;
  localparam logic [EV_W-1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [3:0] OP_LAST_CODE = 4'hC;

  typedef enum logic [3:0] {
    op_read = 4'h0,
    op_status = 4'h1,
    op_reset = 4'h2,
    op_query_exit = 4'h3,
    op_fault_clear = 4'h4,
    op_lock_program = 4'h5,
    op_lock_exit = 4'h6,
    op_secure_word = 4'h7,
    op_buffer_open = 4'h8,
    op_buffer_word = 4'h9,
    op_buffer_confirm = 4'hA,
    op_secure_exit = 4'hB,
    op_write_raw = 4'hC
  } op_t;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_setup = 2'b01,
    st_pulse = 2'b11,
    st_recover = 2'b10
  } state_t;

  typedef struct packed {
    logic is_read;
    logic last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cycle_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
  } flash_bus_t;

endpackage : flash_host_pkg

// File: flash_model.sv
// behavioural flash of the auxiliary modes on plain pins
// assumes ce_n stays low over each command cycle from the host
`timescale 1ns/1ps
module flash_model #(
  parameter int ACC_NS = 50,
  parameter int PROG_NS = 400
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [21:0] addr,
  input wire logic [15:0] dq_w,
  output logic [15:0] dq_r
);
  // mode codes; entry data from read mode are arbitrary
  localparam int RD = 0, FH = 1, F1 = 2, F2 = 3, LK = 4, LA = 5, LB = 6;
  localparam int LX = 7, QT = 8, ID = 9, SC = 10, U1 = 11, U2 = 12;
  localparam int WB = 13, WD = 14, SB = 15, SW = 16, SX = 17;
  int st = RD;
  int left = 0;
  logic [6:0] esa = 7'h00;
  logic c, b, same;
  logic [7:0] d;
  logic prog_end = 1'b0;
  initial dq_r = 16'h5A5A;
  ////////////////////////////////////////////////////////////////////////
  always @(posedge we_n or posedge prog_end)
    if (prog_end) st = st == LB ? LK : SC;
    else if (!ce_n) begin
    d = dq_w[7:0];
    c = addr[10:0] == 11'h555;
    b = addr[10:0] == 11'h2AA;
    same = addr[21:15] == esa;
    case (st) // pairs not listed leave the mode alone
      RD: st = d == 8'h40 ? LK : d == 8'h98 ? QT : d == 8'h90 ? ID :
               d == 8'h88 ? SC : RD;
      FH: if (c && d == 8'hAA) st = F1;
      F1: if (b && d == 8'h55) st = F2;
      F2: if (c && d == 8'hF0) st = SC; // back to the origin
      LK: begin
        if (d == 8'hF0) st = RD;
        else if (d == 8'hA0) st = LA;
        else if (d == 8'h90) st = LX;
      end
      LA: st = LB;
      LX: if (d == 8'h00 || d == 8'hF0) st = RD;
      QT: if (d == 8'hF0 || d == 8'hFF) st = RD;
      ID: if (d == 8'hF0) st = RD;
      SC: if (d == 8'hF0) st = RD; else if (c && d == 8'hAA) st = U1;
      U1: if (b && d == 8'h55) st = U2;
      U2: if (c && d == 8'hA0) st = SW;
          else if (c && d == 8'h90) st = SX;
          else if (d == 8'h25) begin
            st = WB;
            esa = addr[21:15];
          end
      SW: st = SB;
      SX: if (d == 8'h00 || d == 8'hF0) st = RD;
      WB: begin
        left = d;
        st = (left > 127 || !same) ? FH : WD;
      end
      WD: if (left < 0) begin
            if (same && d == 8'h29) st = SB;
          end else if (!same) st = FH;
          else left = left - 1;
      default: ; // busy modes drop f0 since no hang is modelled
    endcase
  end
  ////////////////////////////////////////////////////////////////////////
  // completion is a pulse so only the write process assigns the mode
  always @(st) if (st == LB || st == SB) begin
    #(PROG_NS);
    prog_end = 1'b1;
    #1 prog_end = 1'b0;
  end
  // a released bus flips instead of holding a stale word
  always @(ce_n or oe_n or addr or st)
    if (!ce_n && !oe_n)
      dq_r <= #(ACC_NS) {st[7:0], addr[7:0]};
    else dq_r <= ~dq_r;
endmodule : flash_model

// File: flash_host_ctrl_test.sv
// self-checking bench of the flash host: apb side and flash pins
// assumes flash_model mode codes match the constants below
`timescale 1ns/1ps
module flash_host_ctrl_test;
  import flash_host_pkg::*;
  localparam logic [7:0] RD = 8'h00, FH = 8'h01, LK = 8'h04, SC = 8'h0A;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, slv;
  logic [15:0] dq_in, mdq;
  flash_bus_t fo;
  logic [63:0] expq[$], got[$];
  int n_errors = 0, comparisons = 0;
  logic [1:0] mask = 2'h3;
  flash_host_ctrl flash_host_ctrl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .dq_in(dq_in), .flash_out(fo));
  flash_model flash_model_i (.ce_n(fo.ce_n), .oe_n(fo.oe_n), .we_n(fo.we_n),
    .addr(fo.addr), .dq_w(fo.dq), .dq_r(mdq));
  assign dq_in = fo.dq_oe_n ? mdq : fo.dq;
  initial forever #4 pclk = ~pclk;
  always @(posedge fo.we_n)
    if (!fo.ce_n) got.push_back(64'({fo.addr, fo.dq}));
  ////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk(input string s, input logic [63:0] e,
                     input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      finish_test();
    end
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic ex(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    expq.push_back(64'({a, d}));
  endtask : ex
  task automatic op(input logic [3:0] c, input logic [ADDR_W-1:0] a,
                    input logic [15:0] d, input logic [1:0] ev);
    int i;
    apb(1'b1, OFS_ADDR, 32'(a));
    apb(1'b1, OFS_DATA, 32'(d));
    apb(1'b1, OFS_CTRL, 32'(c));
    i = 0;
    do begin
      apb(1'b0, OFS_IRQ_STATUS, 32'h0);
      i++;
    end while (r[1:0] === 2'h0 && i < 200);
    if (r[1:0] === 2'h0) begin
      n_errors++;
      finish_test();
    end
    chk("event", 64'(ev), 64'(r[1:0]));
    chk("irq", 64'((ev & mask) != 2'h0), 64'(irq));
    apb(1'b1, OFS_IRQ_STATUS, 32'h3);
    chk("irq cleared", 64'h0, 64'(irq));
    chk("cycle count", 64'(expq.size()), 64'(got.size()));
    while (expq.size() > 0 && got.size() > 0)
      chk("flash write", expq.pop_front(), got.pop_front());
    expq.delete();
    got.delete();
  endtask : op
  task automatic raw(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    ex(a, d);
    op(op_write_raw, a, d, 2'h1);
  endtask : raw
  task automatic unlock;
    ex(CMD_ADDR_A, CMD_UNLOCK_A);
    ex(CMD_ADDR_B, CMD_UNLOCK_B);
  endtask : unlock
  task automatic mode(input logic [7:0] m);
    int i;
    logic [ADDR_W-1:0] a;
    a = 22'($urandom);
    i = 0;
    do begin
      op(op_read, a, 16'h0, 2'h1);
      apb(1'b0, OFS_RDATA, 32'h0);
      i++;
    end while (r[15:8] !== m && i < 8);
    chk("read data", 64'({m, a[7:0]}), 64'(r[15:0]));
  endtask : mode
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    logic [ADDR_W-1:0] a, sa;
    logic [15:0] d;
    logic [7:0] n;
    r = $urandom(32'h04e934ce);
    repeat (10) @(posedge pclk);
    chk("idle pins", 64'hF, 64'({fo.ce_n, fo.oe_n, fo.we_n, fo.dq_oe_n}));
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk("mask reset", 64'(IRQ_MASK_RESET), 64'(r));
    apb(1'b0, 12'h0FC, 32'h0);
    chk("pslverr", 64'h1, 64'(slv));
    apb(1'b1, OFS_IRQ_MASK, 32'h3);
    op(4'hD, 22'h0, 16'h0, 2'h2);
    mode(RD);
    a = 22'($urandom);
    d = 16'($urandom);
    raw(a, 16'h0040);
    ex(a, CMD_ARM);
    ex(a, d);
    op(op_lock_program, a, d, 2'h1);
    mode(LK);
    ex(a, CMD_EXIT_ENTRY);
    ex(a, CMD_EXIT);
    op(op_lock_exit, a, 16'h0, 2'h1);
    mode(RD);
    raw(a, 16'h0098);
    ex(a, CMD_QUERY_EXIT);
    op(op_query_exit, a, 16'h0, 2'h1);
    mode(RD);
    raw(a, 16'h0090);
    ex(a, CMD_RESET);
    op(op_reset, a, 16'h0, 2'h1);
    mode(RD);
    raw(a, 16'h0088);
    ex(CMD_ADDR_A, CMD_STATUS);
    op(op_status, a, 16'h0, 2'h1);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk("status read", 64'({SC, a[7:0]}), 64'(r[15:0]));
    unlock();
    ex(CMD_ADDR_A, CMD_ARM);
    ex(a, d);
    op(op_secure_word, a, d, 2'h1);
    mode(SC);
    sa = {7'($urandom), 15'h0};
    apb(1'b1, OFS_COUNT, 32'd200);
    op(op_buffer_open, sa, 16'h0, 2'h2);
    n = 8'($urandom_range(7, 0));
    apb(1'b1, OFS_COUNT, 32'(n));
    unlock();
    ex(sa, CMD_BUF_LOAD);
    ex(sa, 16'(n));
    op(op_buffer_open, sa, 16'h0, 2'h1);
    op(op_buffer_confirm, sa, 16'h0, 2'h2);
    op(op_buffer_word, sa ^ 22'h008000, d, 2'h2);
    for (i = 0; i <= int'(n); i++) begin
      apb(1'b0, OFS_STAT, 32'h0);
      chk("words left", 64'(int'(n) + 1 - i), 64'(r[8:0]));
      a = sa | 22'($urandom_range(32767, 0));
      d = 16'($urandom);
      ex(a, d);
      op(op_buffer_word, a, d, 2'h1);
    end
    op(op_buffer_word, sa, d, 2'h2);
    ex(sa, CMD_CONFIRM);
    op(op_buffer_confirm, sa, 16'h0, 2'h1);
    mode(SC);
    apb(1'b1, OFS_COUNT, 32'h3);
    unlock();
    ex(sa, CMD_BUF_LOAD);
    ex(sa, 16'h3);
    op(op_buffer_open, sa, 16'h0, 2'h1);
    raw(sa ^ 22'h008000, d);
    mode(FH);
    unlock();
    ex(CMD_ADDR_A, CMD_RESET);
    op(op_fault_clear, 22'h0, 16'h0, 2'h1);
    mode(SC);
    unlock();
    ex(CMD_ADDR_A, CMD_EXIT_ENTRY);
    ex(a, CMD_EXIT);
    op(op_secure_exit, a, 16'h0, 2'h1);
    mask = 2'h0;
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    mode(RD);
    finish_test();
  end
endmodule : flash_host_ctrl_test
